// [design/two_wire_eeprom_target_engine.sv]
// Target protocol engine of a two-wire byte-wide nonvolatile memory
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Data change while clock high means start/stop
// - Falling data with clock high starts transaction
// - Rising data with clock high stops, back idle
// - Acknowledge each received byte on ninth clock
// - Idle at power-up and after stop, done
// - Device-type nibble must match before responding
// - Select bits compared to pins, rest page bits
// - Page bits become word address high bits
// - Last address bit picks read or write
// - Match acknowledges, mismatch returns idle silently
// - Byte write then stop launches timed program
// - Ignore bus while program cycle runs
// - Page write accepts further bytes, each acknowledged
// - Write address wraps inside current page
// - Polling acknowledged only after programming completes
// - Address counter keeps last address plus one
// - Read address wraps across whole array
// - Current read sends byte at counter
// - Controller acknowledge continues read, nack ends
// - Sample on rising clock, drive after falling
// - Lock pin high protects whole array
// - Address width seven to eleven bits
module two_wire_eeprom_target_engine #(
  parameter int ADDR_W = eeprom_pkg::ADDR_W_DEFAULT,
  parameter int PAGE_W = eeprom_pkg::PAGE_W_DEFAULT,
  parameter logic [3:0] DEVICE_TYPE = eeprom_pkg::DEVICE_TYPE_DEFAULT,
  parameter int PROGRAM_CYCLES = eeprom_pkg::PROGRAM_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic link_clk,
  input wire eeprom_pkg::bus_pins_s bus_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_bit2,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit0,
  input wire logic array_lock,
  output logic program_busy
);

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int DEPTH = 1 << ADDR_W; // Bytes in the array
  localparam int PAGE = 1 << PAGE_W; // Bytes in one page
  // Address-word bits taken as page bits; the rest are select bits
  localparam int PAGE_HI = (ADDR_W > 8) ? ADDR_W - 8 : 0;

  // ==========================================================
  // Link domain state (runs on link_clk)
  // ==========================================================
  typedef struct packed {
    logic rst1; // Reset synchroniser, first stage
    logic rst2; // Reset synchroniser, second stage
    eeprom_pkg::link_inputs_s s1; // Pin synchroniser, first stage
    eeprom_pkg::link_inputs_s s2; // Pin synchroniser, second stage
    eeprom_pkg::link_inputs_s prev; // Last settled sample, for edges
    eeprom_pkg::phase_e phase; // Protocol phase
    logic [3:0] cnt; // Bits counted in the current byte
    logic [7:0] shreg; // Byte shifter, both directions
    logic [2:0] dev_hi; // Low address-word bits, page source
    logic rw; // Direction of this transaction
    logic [ADDR_W-1:0] addr; // Persistent word address counter
    logic [ADDR_W-1:0] page_base; // Page being filled
    logic [PAGE-1:0] pmask; // Bytes of the page buffer in use
    logic [PAGE-1:0][7:0] pbuf; // Page buffer awaiting program
    logic [DEPTH-1:0][7:0] mem; // The array itself
    logic busy; // Program cycle pending
    logic req_tog; // Program request toggle to mclk side
    logic done_seen; // Last done toggle consumed
    logic oe; // Pulling the data line low
    logic dout; // Driven level, always low (open drain)
  } link_state_s;

  // ==========================================================
  // Program timer state (runs on mclk)
  // ==========================================================
  typedef struct packed {
    logic req1; // Request toggle synchroniser, first stage
    logic req2; // Request toggle synchroniser, second stage
    logic req_prev; // Last settled request toggle
    logic busy; // Timer running
    logic [eeprom_pkg::PROG_CNT_W-1:0] cnt; // Elapsed cycles
    logic done_tog; // Completion toggle to link side
  } prog_state_s;

  link_state_s l;
  link_state_s next_l;
  prog_state_s p;
  prog_state_s next_p;
  eeprom_pkg::link_inputs_s raw; // Unsynchronised inputs

  // Gather everything arriving from outside link_clk
  assign raw.scl = bus_in.scl;
  assign raw.sda = bus_in.sda;
  assign raw.lock = array_lock;
  assign raw.sel = {chip_select_bit2, chip_select_bit1, chip_select_bit0};
  assign raw.done_tog = p.done_tog;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Address word compare: type nibble plus the select bits in use
  function automatic logic addr_match(input logic [7:0] w, input logic [2:0] pins);
    logic [2:0] mask;
    mask = 3'(3'b111 << PAGE_HI);
    addr_match = (w[7:4] == DEVICE_TYPE) && (((w[3:1] ^ pins) & mask) == 3'b000);
  endfunction

  // Open-drain drive for one outgoing bit: pull low only for a zero
  function automatic logic drive_bit(input logic b);
    drive_bit = ~b;
  endfunction

  // ==========================================================
  // Link engine: next state
  // ==========================================================
  // Start/stop take priority over clock edges, so a frame edge
  // always wins even if both show up in one sample.
  always_comb begin
    logic rise;
    logic fall;
    logic start_ev;
    logic stop_ev;
    logic done_ev;
    logic [PAGE_W-1:0] idx;
    logic [ADDR_W-1:0] wa;
    rise = 1'b0;
    fall = 1'b0;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    done_ev = 1'b0;
    idx = '0;
    wa = '0;
    next_l = l;
    // Synchronisers always run, also through reset
    next_l.rst1 = rst;
    next_l.rst2 = l.rst1;
    next_l.s1 = raw;
    next_l.s2 = l.s1;
    next_l.prev = l.s2;
    if (l.rst2) begin
      // Power-up: idle, counter cleared, array contents kept
      next_l.phase = eeprom_pkg::PH_IDLE;
      next_l.cnt = 4'h0;
      next_l.shreg = eeprom_pkg::SHIFT_RESET;
      next_l.dev_hi = 3'b000;
      next_l.rw = 1'b0;
      next_l.addr = ADDR_W'(eeprom_pkg::ADDR_RESET);
      next_l.page_base = ADDR_W'(eeprom_pkg::ADDR_RESET);
      next_l.pmask = '0;
      next_l.pbuf = '0;
      next_l.busy = 1'b0;
      next_l.req_tog = 1'b0;
      next_l.done_seen = l.s2.done_tog;
      next_l.oe = 1'b0;
      next_l.dout = 1'b0;
    end else begin
      rise = l.s2.scl & ~l.prev.scl;
      fall = ~l.s2.scl & l.prev.scl;
      // Data moving while clock stays high is a frame edge
      start_ev = l.s2.scl & l.prev.scl & l.prev.sda & ~l.s2.sda;
      stop_ev = l.s2.scl & l.prev.scl & ~l.prev.sda & l.s2.sda;
      done_ev = l.s2.done_tog ^ l.done_seen;
      next_l.dout = 1'b0;
      // Program finished: commit the buffered page to the array
      if (done_ev) begin
        next_l.done_seen = l.s2.done_tog;
        next_l.busy = 1'b0;
        for (int i = 0; i < PAGE; i++) begin
          wa = ADDR_W'({l.page_base[ADDR_W-1:PAGE_W], PAGE_W'(i)});
          if (l.pmask[i]) begin
            next_l.mem[wa] = l.pbuf[i];
          end
        end
        next_l.pmask = '0;
      end
      if (start_ev) begin
        // New transaction; while programming the bus is ignored
        next_l.oe = 1'b0;
        next_l.cnt = 4'h0;
        next_l.pmask = l.busy ? l.pmask : '0;
        next_l.phase = l.busy ? eeprom_pkg::PH_IDLE : eeprom_pkg::PH_DEV;
      end else if (stop_ev) begin
        next_l.oe = 1'b0;
        next_l.phase = eeprom_pkg::PH_IDLE;
        // The stop's own clock rise counted one bit, so cnt of 1
        // means the stop came right on a byte boundary.
        if (l.phase == eeprom_pkg::PH_WDATA && l.cnt == 4'h1 && l.pmask != '0
            && !l.busy && !l.s2.lock) begin
          next_l.busy = 1'b1;
          next_l.req_tog = ~l.req_tog;
        end else if (!l.busy) begin
          // Locked or aborted mid-byte: drop what was buffered
          next_l.pmask = '0;
        end
      end else if (rise) begin
        case (l.phase)
          eeprom_pkg::PH_DEV,
          eeprom_pkg::PH_WADDR,
          eeprom_pkg::PH_WDATA: begin
            // Sample a bit into the shifter
            next_l.shreg = {l.shreg[6:0], l.s2.sda};
            next_l.cnt = l.cnt + 4'h1;
          end
          eeprom_pkg::PH_RACK: begin
            // Controller's answer: low continues, high ends the read
            if (l.s2.sda) begin
              next_l.phase = eeprom_pkg::PH_IDLE;
            end
          end
          default: begin
            // Other phases sample nothing
            next_l.cnt = l.cnt;
          end
        endcase
      end else if (fall) begin
        case (l.phase)
          eeprom_pkg::PH_DEV: begin
            if (l.cnt == 4'(eeprom_pkg::WORD_BITS)) begin
              if (addr_match(l.shreg, l.s2.sel)) begin
                next_l.oe = 1'b1;
                next_l.dev_hi = l.shreg[3:1];
                next_l.rw = l.shreg[0];
                next_l.phase = eeprom_pkg::PH_DEV_ACK;
              end else begin
                next_l.phase = eeprom_pkg::PH_IDLE;
              end
            end
          end
          eeprom_pkg::PH_WADDR: begin
            if (l.cnt == 4'(eeprom_pkg::WORD_BITS)) begin
              // Page bits from the address word sit on top
              next_l.addr = ADDR_W'({l.dev_hi, l.shreg});
              next_l.oe = 1'b1;
              next_l.phase = eeprom_pkg::PH_WADDR_ACK;
            end
          end
          eeprom_pkg::PH_WDATA: begin
            if (l.cnt == 4'(eeprom_pkg::WORD_BITS)) begin
              // Buffer the byte; only the in-page bits advance
              idx = l.addr[PAGE_W-1:0];
              next_l.pbuf[idx] = l.shreg;
              next_l.pmask[idx] = 1'b1;
              next_l.page_base = l.addr;
              next_l.addr[PAGE_W-1:0] = idx + PAGE_W'(1);
              next_l.oe = 1'b1;
              next_l.phase = eeprom_pkg::PH_WDATA_ACK;
            end
          end
          eeprom_pkg::PH_DEV_ACK: begin
            next_l.cnt = 4'h0;
            if (l.rw) begin
              // Current-address read: first bit goes out now
              next_l.shreg = l.mem[l.addr];
              next_l.addr = l.addr + ADDR_W'(1);
              next_l.oe = drive_bit(l.mem[l.addr][7]);
              next_l.phase = eeprom_pkg::PH_RDATA;
            end else begin
              next_l.oe = 1'b0;
              next_l.pmask = '0;
              next_l.phase = eeprom_pkg::PH_WADDR;
            end
          end
          eeprom_pkg::PH_WADDR_ACK,
          eeprom_pkg::PH_WDATA_ACK: begin
            // Release after the ninth clock, then take data bytes
            next_l.oe = 1'b0;
            next_l.cnt = 4'h0;
            next_l.phase = eeprom_pkg::PH_WDATA;
          end
          eeprom_pkg::PH_RDATA: begin
            if (l.cnt == 4'h7) begin
              // Let go so the controller can answer
              next_l.oe = 1'b0;
              next_l.phase = eeprom_pkg::PH_RACK;
            end else begin
              next_l.cnt = l.cnt + 4'h1;
              next_l.shreg = {l.shreg[6:0], 1'b0};
              next_l.oe = drive_bit(l.shreg[6]);
            end
          end
          eeprom_pkg::PH_RACK: begin
            // Acknowledged: next byte, wrapping over the whole array
            next_l.cnt = 4'h0;
            next_l.shreg = l.mem[l.addr];
            next_l.addr = l.addr + ADDR_W'(1);
            next_l.oe = drive_bit(l.mem[l.addr][7]);
            next_l.phase = eeprom_pkg::PH_RDATA;
          end
          default: begin
            next_l.oe = 1'b0;
          end
        endcase
      end
    end
  end

  // Link engine registers
  always_ff @(posedge link_clk) begin
    l <= next_l;
  end

  // ==========================================================
  // Program timer: next state
  // ==========================================================
  // Runs on the free system clock so the cycle ends even when the
  // controller has stopped clocking the bus.
  always_comb begin
    next_p = p;
    next_p.req1 = l.req_tog;
    next_p.req2 = p.req1;
    next_p.req_prev = p.req2;
    if (rst) begin
      next_p.req_prev = 1'b0;
      next_p.busy = 1'b0;
      next_p.cnt = '0;
      next_p.done_tog = 1'b0;
    end else if (p.busy) begin
      if (p.cnt == eeprom_pkg::PROG_CNT_W'(PROGRAM_CYCLES - 1)) begin
        next_p.busy = 1'b0;
        next_p.done_tog = ~p.done_tog;
      end else begin
        next_p.cnt = p.cnt + eeprom_pkg::PROG_CNT_W'(1);
      end
    end else if (p.req2 ^ p.req_prev) begin
      next_p.busy = 1'b1;
      next_p.cnt = '0;
    end
  end

  // Program timer registers
  always_ff @(posedge mclk) begin
    p <= next_p;
  end

  // ==========================================================
  // Outputs, all straight from flip-flops
  // ==========================================================
  assign sda_out = l.dout;
  assign sda_oe = l.oe;
  assign program_busy = p.busy;

endmodule

`default_nettype wire

// [include/eeprom_pkg.sv]
// Shared constants, types and carriers of the two-wire memory target engine
package eeprom_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  // Longest internal program time, in milliseconds
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  // System clock period in nanoseconds (10 MHz)
  localparam int MCLK_PERIOD_NS = 100;
  // Longest time rounds down to whole system clock cycles
  localparam int PROGRAM_CYCLES = (PROGRAM_CYCLE_TIME_MS * 1_000_000) / MCLK_PERIOD_NS;
  // Width of the program cycle counter
  localparam int PROG_CNT_W = 24;

  // ==========================================================
  // Geometry and address word
  // ==========================================================
  // Word address width (7 to 11 across capacities)
  localparam int ADDR_W_DEFAULT = 8;
  // Log2 of page size: 3 for 8-byte pages, 4 for 16-byte pages
  localparam int PAGE_W_DEFAULT = 3;
  // Bits per transferred word
  localparam int WORD_BITS = 8;
  // Device-type code in the top nibble; value is arbitrary
  localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h6;
  // Reset value of the persistent word address counter
  localparam logic [10:0] ADDR_RESET = 11'h000;
  // Reset value of a transmitted byte shifter
  localparam logic [7:0] SHIFT_RESET = 8'h00;

  // ==========================================================
  // Types
  // ==========================================================
  // Protocol phases of the link engine
  typedef enum logic [3:0] {
    PH_IDLE,
    PH_DEV,
    PH_DEV_ACK,
    PH_WADDR,
    PH_WADDR_ACK,
    PH_WDATA,
    PH_WDATA_ACK,
    PH_RDATA,
    PH_RACK
  } phase_e;

  // Two-wire bus levels as seen at the pins
  typedef struct packed {
    logic scl;
    logic sda;
  } bus_pins_s;

  // Everything the link domain samples from outside its own clock
  typedef struct packed {
    logic scl;
    logic sda;
    logic lock;
    logic [2:0] sel;
    logic done_tog;
  } link_inputs_s;

endpackage

// [bench/eeprom_target_props.sv]
// Port checker of the two-wire memory target engine
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module eeprom_target_props #(
  parameter int PROGRAM_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic link_clk,
  input wire eeprom_pkg::bus_pins_s bus_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic array_lock,
  input wire logic program_busy
);
  // Busy length; wide enough for the full program count
  logic [23:0] busy_len;
  // Counts mclk edges seen with busy high
  always_ff @(posedge mclk) begin
    if (rst || !program_busy) begin
      busy_len <= 24'h00_0000;
    end else begin
      busy_len <= busy_len + 24'h00_0001;
    end
  end
  a_drive_low_only:
    assert property (@(posedge link_clk) disable iff (rst) sda_oe |-> !sda_out)
    else $error("data line driven high");
  a_oe_scl_low:
    assert property (@(posedge link_clk) disable iff (rst) $changed(sda_oe) |-> !bus_in.scl)
    else $error("data line changed with clock high");
  a_oe_holds:
    assert property (@(posedge link_clk) disable iff (rst) $rose(sda_oe) |-> sda_oe [*8])
    else $error("driven bit too short");
  a_start_quiet:
    assert property (@(posedge link_clk) disable iff (rst)
      bus_in.scl && $fell(bus_in.sda) |=> !sda_oe [*8]) else $error("drive right after start");
  a_stop_quiet:
    assert property (@(posedge link_clk) disable iff (rst)
      bus_in.scl && $rose(bus_in.sda) |=> !sda_oe [*8]) else $error("drive right after stop");
  a_reset_idle:
    assert property (@(posedge mclk) disable iff (rst) $fell(rst) |-> !program_busy [*4])
    else $error("busy after reset");
  a_busy_length:
    assert property (@(posedge mclk) disable iff (rst)
      $fell(program_busy) |-> busy_len == 24'(PROGRAM_CYCLES)) else $error("program time wrong");
  a_busy_silent:
    assert property (@(posedge mclk) disable iff (rst) program_busy |-> !sda_oe)
    else $error("answer during program");
  a_lock_blocks:
    assert property (@(posedge mclk) disable iff (rst) $rose(program_busy) |-> !array_lock)
    else $error("program while locked");
  c_program: cover property (@(posedge mclk) disable iff (rst) $rose(program_busy));
  c_ack: cover property (@(posedge link_clk) disable iff (rst) $rose(sda_oe));
  c_stop: cover property (@(posedge link_clk) disable iff (rst) bus_in.scl && $rose(bus_in.sda));
endmodule

bind two_wire_eeprom_target_engine eeprom_target_props #(
  .PROGRAM_CYCLES(PROGRAM_CYCLES)
) eeprom_target_props_inst (
  .mclk(mclk), .rst(rst), .link_clk(link_clk), .bus_in(bus_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .array_lock(array_lock), .program_busy(program_busy)
);
`default_nettype wire

// [bench/bus_ctl_model.sv]
// Bus controller model driving the two-wire link from the far side
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Controller model
module bus_ctl_model (
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // Both lines idle high; clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Quarter bit of two cycles keeps each phase over six link cycles
  task automatic quarter;
    repeat (2) @(negedge mclk);
  endtask
  // Start, also a repeated start from clock low
  task automatic start_cond;
    sda_drv = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sda_drv = 1'b0;
    quarter();
    scl = 1'b0;
    quarter();
  endtask
  // Stop from clock low
  task automatic stop_cond;
    sda_drv = 1'b0;
    quarter();
    scl = 1'b1;
    quarter();
    sda_drv = 1'b1;
    quarter();
  endtask
  // One bit: data set while clock low, line read mid high phase
  task automatic bit_xfer(input logic b, output logic r);
    sda_drv = b;
    quarter();
    scl = 1'b1;
    quarter();
    r = sda_line;
    quarter();
    scl = 1'b0;
    quarter();
  endtask
  // Byte out, MSB first, then the device's answer bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack);
  endtask
  // Byte in with the line released, then our own answer bit
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(ack, r);
  endtask
  // Clears a half-finished transfer before the first start
  task automatic recover;
    logic r;
    r = 1'b0;
    for (int i = 0; i < 9 && r !== 1'b1; i++) begin
      bit_xfer(1'b1, r);
    end
    start_cond();
  endtask
endmodule
`default_nettype wire

// [bench/two_wire_eeprom_target_engine_tb.sv]
// Self-checking bench of the two-wire memory target engine
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench top
module two_wire_eeprom_target_engine_tb;
  localparam int PROG = 200; // Short program time keeps the run brief
  logic mclk, link_clk, rst, lock, scl, sda_drv, sda_line, sda_out, sda_oe, busy, a;
  logic [2:0] sel;
  logic [7:0] dev_w, dev_r;
  logic [7:0] expq[$]; // Bytes expected by the next read
  eeprom_pkg::bus_pins_s bus_in;
  int failures = 0;
  int compares = 0;
  // Open-drain wire with pull-up
  assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
  assign bus_in = {scl, sda_line};
  assign dev_w = {eeprom_pkg::DEVICE_TYPE_DEFAULT, sel, 1'b0};
  assign dev_r = dev_w | 8'h01;
  two_wire_eeprom_target_engine #(
    .PROGRAM_CYCLES(PROG)
  ) two_wire_eeprom_target_engine_inst (
    .mclk(mclk), .rst(rst), .link_clk(link_clk), .bus_in(bus_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_select_bit2(sel[2]), .chip_select_bit1(sel[1]),
    .chip_select_bit0(sel[0]), .array_lock(lock), .program_busy(busy)
  );
  bus_ctl_model bus_ctl_model_inst (
    .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
  );
  // ==========================================
  // Clocks, unrelated in phase
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  // ==========================================
  // Compare and closing tasks
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // Transaction helpers
  task automatic open_write(input logic [7:0] addr);
    bus_ctl_model_inst.start_cond();
    bus_ctl_model_inst.send_byte(dev_w, a);
    check_bit(a, 1'b0);
    bus_ctl_model_inst.send_byte(addr, a);
    check_bit(a, 1'b0);
  endtask
  // Reads the queued bytes; last one unanswered, then stop
  task automatic read_rest;
    logic [7:0] d;
    for (int i = 0; i < expq.size(); i++) begin
      bus_ctl_model_inst.recv_byte(i == expq.size() - 1, d);
      check_byte(d, expq[i]);
    end
    bus_ctl_model_inst.stop_cond();
  endtask
  task automatic cur_read;
    bus_ctl_model_inst.start_cond();
    bus_ctl_model_inst.send_byte(dev_r, a);
    check_bit(a, 1'b0);
    read_rest();
  endtask
  task automatic read_at(input logic [7:0] addr);
    open_write(addr);
    cur_read();
  endtask
  // Bounded wait for the program timer; exp says whether it must start
  task automatic wait_prog(input logic exp);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 30) begin
      @(negedge mclk);
      n++;
    end
    check_bit(busy, exp);
    while (busy !== 1'b0 && n < 2 * PROG) begin
      @(negedge mclk);
      n++;
    end
    // A timer that never ends counts as a mismatch
    check_bit(busy, 1'b0);
  endtask
  // ==========================================
  // Scenarios
  task automatic page_wrap_poll;
    int tries;
    open_write(8'h06);
    for (int i = 0; i < 10; i++) begin
      bus_ctl_model_inst.send_byte(8'hA0 + 8'(i), a);
      check_bit(a, 1'b0);
    end
    bus_ctl_model_inst.stop_cond();
    tries = 0;
    a = 1'b1;
    while (a !== 1'b0 && tries < 20) begin
      bus_ctl_model_inst.start_cond();
      bus_ctl_model_inst.send_byte(dev_w, a);
      tries++;
    end
    check_bit(tries > 1, 1'b1);
    check_bit(a, 1'b0);
    bus_ctl_model_inst.send_byte(8'h00, a);
    check_bit(a, 1'b0);
    for (int i = 0; i < 8; i++) begin
      expq.push_back(8'hA2 + 8'(i));
    end
    cur_read();
  endtask
  task automatic array_wrap;
    open_write(8'hFF);
    bus_ctl_model_inst.send_byte(8'h5C, a);
    check_bit(a, 1'b0);
    bus_ctl_model_inst.stop_cond();
    wait_prog(1'b1);
    expq = '{8'h5C, 8'hA2};
    read_at(8'hFF);
    expq = '{8'hA3};
    cur_read();
  endtask
  task automatic wrong_address;
    logic [7:0] flip[3];
    flip = '{8'h02, 8'h08, 8'h10};
    foreach (flip[i]) begin
      bus_ctl_model_inst.start_cond();
      bus_ctl_model_inst.send_byte(dev_w ^ flip[i], a);
      check_bit(a, 1'b1);
    end
    bus_ctl_model_inst.stop_cond();
  endtask
  task automatic locked_write;
    lock = 1'b1;
    open_write(8'h01);
    bus_ctl_model_inst.send_byte(8'h11, a);
    check_bit(a, 1'b0);
    bus_ctl_model_inst.stop_cond();
    wait_prog(1'b0);
    lock = 1'b0;
    expq = '{8'hA3};
    read_at(8'h01);
  endtask
  // One whole byte is buffered, then a cut byte must discard it
  task automatic abort_write;
    open_write(8'h02);
    bus_ctl_model_inst.send_byte(8'h77, a);
    check_bit(a, 1'b0);
    for (int i = 0; i < 4; i++) begin
      bus_ctl_model_inst.bit_xfer(1'b0, a);
    end
    bus_ctl_model_inst.stop_cond();
    wait_prog(1'b0);
    expq = '{8'hA4};
    read_at(8'h02);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    lock = 1'b0;
    sel = 3'b101;
    repeat (8) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    bus_ctl_model_inst.recover();
    bus_ctl_model_inst.stop_cond();
    page_wrap_poll();
    array_wrap();
    wrong_address();
    locked_write();
    abort_write();
    wrap_up();
  end
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
